// ===== core/sbsm_manch_enc.sv
// Manchester frame encoder with start bits and trailing idle bit
`timescale 1ns/10ps
module sbsm_manch_enc #(
	parameter int DATA_W = sbsm_pkg::DATA_BITS,
	parameter int HALF_CYC = sbsm_pkg::HALF_BIT_CYC
) (
	input wire logic aclk, // Clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic start, // Start a frame
	input wire logic phase, // Manchester phase select
	input wire logic [DATA_W-1:0] data, // Frame payload
	output logic line, // Modulation level
	output logic busy, // Frame or idle bit in progress
	output logic done // Pulse after the idle bit
);
	import sbsm_pkg::*;

	localparam int TOT = DATA_W + START_BITS;

	typedef struct packed {
		logic [TOT-1:0] sh;
		logic [4:0] bitn;
		logic [8:0] cnt;
		logic half;
		logic idle;
		logic line;
		logic busy;
		logic done;
	} sbsm_enc_t;

	sbsm_enc_t s_r, s_nxt;

	// First half level; second half is its inverse so the edge lands mid-bit
	function automatic logic first_half(input logic b, input logic ph);
		first_half = ~(b ^ ph);
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (!s_r.busy) begin
			if (start) begin
				s_nxt.sh = {~phase, 1'b0, data};
				s_nxt.bitn = 5'(TOT);
				s_nxt.cnt = 9'(HALF_CYC - 1);
				s_nxt.half = 1'b0;
				s_nxt.idle = 1'b0;
				s_nxt.busy = 1'b1;
				s_nxt.line = first_half(~phase, phase);
			end
		end else if (s_r.cnt != 9'h0) begin
			s_nxt.cnt = s_r.cnt - 9'h1;
		end else begin
			s_nxt.cnt = 9'(HALF_CYC - 1);
			if (!s_r.half) begin
				s_nxt.half = 1'b1;
				s_nxt.line = s_r.idle ? 1'b0 : ~s_r.line;
			end else if (s_r.idle) begin
				s_nxt.busy = 1'b0;
				s_nxt.idle = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.half = 1'b0;
				s_nxt.sh = {s_r.sh[TOT-2:0], 1'b0};
				s_nxt.bitn = s_r.bitn - 5'h1;
				if (s_r.bitn == 5'h1) begin
					s_nxt.idle = 1'b1;
					s_nxt.line = 1'b0;
				end else begin
					s_nxt.line = first_half(s_r.sh[TOT-2], phase);
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign line = s_r.line;
	assign busy = s_r.busy;
	assign done = s_r.done;

	property p_mid_edge;
		@(posedge aclk) disable iff (!rstn)
		s_r.busy && !s_r.idle && !s_r.half && s_r.cnt == 9'h0 |=> s_r.line != $past(s_r.line);
	endproperty
	a_mid_edge: assert property (p_mid_edge) else $error("no mid-bit transition");

	// First start bit is 1 by default, 0 inverted: it rises either way, so starts low
	property p_first_start_bit;
		@(posedge aclk) disable iff (!rstn)
		start && !s_r.busy |=> s_r.busy && !s_r.line;
	endproperty
	a_first_start_bit: assert property (p_first_start_bit) else $error("bad first start bit");
endmodule

// ===== core/sbsm_pkg.sv
// Shared constants and types for the sensor bus sync/Manchester transmitter
package sbsm_pkg;
	// Clock and derived timing counts
	localparam int CLK_NS = 20;
	localparam int FRAME_PERIOD_NS = 228000;
	localparam int FRAME_PERIOD_CYC = FRAME_PERIOD_NS / CLK_NS;
	localparam int SYNC_TICK_NS = 1000;
	localparam int SYNC_TICK_CYC = SYNC_TICK_NS / CLK_NS;
	localparam int BIT_TIME_NS = 8000;
	localparam int HALF_BIT_CYC = BIT_TIME_NS / 2 / CLK_NS;
	localparam int DISCH_NS = 20000;
	localparam int DISCH_CYC = DISCH_NS / CLK_NS;
	localparam int CNT_W = 14;

	// Frame and validator layout
	localparam int DATA_BITS = 10;
	localparam int START_BITS = 2;
	localparam logic [2:0] SYNC_VALID_CNT = 3'h7;

	// Register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
	localparam logic [3:0] REG_STAT_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA_ADDR = 4'h8;
	localparam int CTRL_PHASE_BIT = 0;
	localparam int CTRL_SYNC_BIT = 1;
	localparam int CTRL_DISCH_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int STAT_ERR_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_DISCH_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Device phase sequence
	typedef enum logic [2:0] {
		ST_INIT_CONV = 3'b001,
		ST_INIT_WAIT = 3'b010,
		ST_RUN = 3'b100
	} sbsm_phase_t;
endpackage

// ===== core/sbsm_sync_val.sv
// Sync pulse validator: up-down integrating counter stepped every microsecond
`timescale 1ns/10ps
module sbsm_sync_val #(
	parameter int TICK_CYC = sbsm_pkg::SYNC_TICK_CYC
) (
	input wire logic aclk, // Clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic en, // Validator enabled
	input wire logic rearm, // End of idle bit after a frame
	input wire logic above, // Bus above upper threshold, synchronised
	input wire logic below, // Bus below lower threshold, synchronised
	output logic valid // One-cycle valid pulse
);
	import sbsm_pkg::*;

	typedef struct packed {
		logic [5:0] tick;
		logic [2:0] cnt;
		logic blank;
		logic valid;
	} sbsm_val_t;

	sbsm_val_t s_r, s_nxt;
	logic tick_now;

	// Tick, counting and blanking
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		tick_now = (s_r.tick == 6'(TICK_CYC - 1));
		s_nxt.tick = tick_now ? 6'h0 : s_r.tick + 6'h1;
		if (!en) begin
			s_nxt.cnt = 3'h0;
			s_nxt.blank = 1'b0;
		end else if (s_r.blank) begin
			if (rearm) begin
				s_nxt.blank = 1'b0;
			end
		end else if (tick_now) begin
			if (s_r.cnt == SYNC_VALID_CNT) begin
				s_nxt.valid = 1'b1;
				s_nxt.blank = 1'b1;
				s_nxt.cnt = 3'h0;
			end else if (above) begin
				s_nxt.cnt = s_r.cnt + 3'h1;
			end else if (below && s_r.cnt != 3'h0) begin
				s_nxt.cnt = s_r.cnt - 3'h1;
			end
			// Between thresholds the count holds; residue persists
		end
	end

	always_ff @(posedge aclk) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign valid = s_r.valid;

	property p_valid_after_seven;
		@(posedge aclk) disable iff (!rstn)
		$rose(s_r.valid) |-> $past(s_r.cnt) == SYNC_VALID_CNT && $past(tick_now);
	endproperty
	a_valid_after_seven: assert property (p_valid_after_seven) else $error("valid without count 7");

	property p_blank_freezes;
		@(posedge aclk) disable iff (!rstn)
		s_r.blank && en |=> s_r.cnt == 3'h0;
	endproperty
	a_blank_freezes: assert property (p_blank_freezes) else $error("counter moved while blanked");

	property p_floor_zero;
		@(posedge aclk) disable iff (!rstn)
		s_r.cnt == 3'h0 && !above |=> s_r.cnt == 3'h0;
	endproperty
	a_floor_zero: assert property (p_floor_zero) else $error("counter went below zero");
endmodule

// ===== core/sbsm_tx.sv
// Top: register slave, sync/async scheduling, error latch and discharge control
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps

// Functional notes
// - Phase bit 0 codes 0 falling, 1 rising; phase bit 1 inverts both.
// - Frames open with start bits 1,0 (default phase) or 0,0 (inverted).
// - Regulator or bus undervoltage report puts the device into reset.
// - Overvoltage report from the regulator monitor sets an internal error.
// - Async mode sends one data frame every 228 us after initialisation.
// - Sync mode starts one conversion per valid pulse, never continuously.
// - Conversion result is held until the next conversion completes.
// - A conversion completes before run-time phase 5 is entered.
// - After an internal error every frame carries the error code.
// - Sync-enable bit: 0 free-running schedule, 1 waits for sync pulses.
// - With sync enabled, one message follows each valid sync pulse.
// - Validator counter steps each 1 us: up above upper, down below lower.
// - Validator counter never goes below zero.
// - Pulse is valid on the counter clock after reaching seven.
// - Counter is blanked after a valid pulse; conversion start follows.
// - Detector re-arms after the idle bit following the last data bit.
// - Residual counts from a short pulse persist into the next pulse.
// - Discharge bit defaults off and acts only while sync is enabled.
// - With discharge active, pull-down current rises on each valid pulse.
// - In sync mode nothing is sent before a valid sync pulse.
module sbsm_tx #(
	parameter int FRAME_CYC = sbsm_pkg::FRAME_PERIOD_CYC,
	parameter logic [sbsm_pkg::DATA_BITS-1:0] ERR_CODE = 10'h3ff
) (
	input wire logic aclk, // Clock, 50 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [sbsm_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [sbsm_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic bus_above_upper, // Bus above sync upper threshold, pin
	input wire logic bus_below_lower, // Bus below sync lower threshold, pin
	input wire logic regulator_undervolt, // Regulator or bus below reset threshold, pin
	input wire logic regulator_overvolt, // Regulator overvoltage, pin
	output logic adc_start, // Conversion start pulse
	input wire logic adc_done, // Conversion complete pulse
	input wire logic [sbsm_pkg::DATA_BITS-1:0] adc_data, // Conversion result
	output logic line_mod, // Current modulation level
	output logic discharge_pull_current // Bus discharge pull-down enable
);
	import sbsm_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sbsm_axi_t;

	typedef struct packed {
		logic [3:0] syn1;
		logic [3:0] syn2;
		sbsm_axi_t ax;
		sbsm_phase_t state;
		logic [2:0] ctrl;
		logic err;
		logic [DATA_BITS-1:0] held;
		logic [CNT_W-1:0] cnt;
		logic disch;
		logic adc_go;
		logic enc_go;
		logic [DATA_BITS-1:0] word;
	} sbsm_top_t;

	sbsm_top_t s_r, s_nxt;
	logic uv, ov, above_s, below_s, rst_int_n;
	logic phase_sel, sync_en, disch_en;
	logic sync_valid, enc_busy, enc_done, trigger;

	// Address decode shared by read and write paths
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == REG_CTRL_ADDR) || (a == REG_STAT_ADDR) || (a == REG_DATA_ADDR);
	endfunction

	// Decoded views of the synchronised pins and control bits
	assign above_s = s_r.syn2[3];
	assign below_s = s_r.syn2[2];
	assign uv = s_r.syn2[1];
	assign ov = s_r.syn2[0];
	assign rst_int_n = aresetn && !uv;
	assign phase_sel = s_r.ctrl[CTRL_PHASE_BIT];
	assign sync_en = s_r.ctrl[CTRL_SYNC_BIT];
	assign disch_en = s_r.ctrl[CTRL_DISCH_BIT];
	assign trigger = sync_en ? sync_valid : (s_r.cnt == '0);

	sbsm_sync_val #(
		.TICK_CYC(SYNC_TICK_CYC)
	) u_val (
		.aclk(aclk),
		.rstn(rst_int_n),
		.en(sync_en && s_r.state == ST_RUN),
		.rearm(enc_done),
		.above(above_s),
		.below(below_s),
		.valid(sync_valid)
	);

	sbsm_manch_enc #(
		.DATA_W(DATA_BITS),
		.HALF_CYC(HALF_BIT_CYC)
	) u_enc (
		.aclk(aclk),
		.rstn(rst_int_n),
		.start(s_r.enc_go),
		.phase(phase_sel),
		.data(s_r.word),
		.line(line_mod),
		.busy(enc_busy),
		.done(enc_done)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.adc_go = 1'b0;
		s_nxt.enc_go = 1'b0;
		// Two-flop pin synchronisers
		s_nxt.syn1 = {bus_above_upper, bus_below_lower, regulator_undervolt, regulator_overvolt};
		s_nxt.syn2 = s_r.syn1;

		// Register bus: capture address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.ax.aw_got = 1'b1;
			s_nxt.ax.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.ax.w_got = 1'b1;
			s_nxt.ax.wdata = s_axi_wdata;
			s_nxt.ax.wstrb0 = s_axi_wstrb[0];
		end
		if (s_r.ax.aw_got && s_r.ax.w_got) begin
			s_nxt.ax.aw_got = 1'b0;
			s_nxt.ax.w_got = 1'b0;
			s_nxt.ax.bvalid = 1'b1;
			s_nxt.ax.bresp = reg_hit(s_r.ax.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.ax.awaddr == REG_CTRL_ADDR && s_r.ax.wstrb0) begin
				s_nxt.ctrl = s_r.ax.wdata[2:0];
			end
		end
		if (s_r.ax.bvalid && s_axi_bready) begin
			s_nxt.ax.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.ax.rvalid = 1'b1;
			s_nxt.ax.rresp = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				REG_CTRL_ADDR: s_nxt.ax.rdata = {29'h0, s_r.ctrl};
				REG_STAT_ADDR: s_nxt.ax.rdata = {28'h0, s_r.disch, enc_busy,
					s_r.state == ST_RUN, s_r.err};
				REG_DATA_ADDR: s_nxt.ax.rdata = {22'h0, s_r.held};
				default: s_nxt.ax.rdata = 32'h0;
			endcase
		end else if (s_r.ax.rvalid && s_axi_rready) begin
			s_nxt.ax.rvalid = 1'b0;
		end

		// Internal error is sticky until a reset
		if (ov) begin
			s_nxt.err = 1'b1;
		end

		// Each finished conversion replaces the held result
		if (adc_done) begin
			s_nxt.held = adc_data;
		end

		// Phase sequence and frame scheduling
		case (s_r.state)
			ST_INIT_CONV: begin
				s_nxt.adc_go = 1'b1;
				s_nxt.state = ST_INIT_WAIT;
			end
			ST_INIT_WAIT: begin
				if (adc_done) begin
					s_nxt.state = ST_RUN;
					s_nxt.cnt = CNT_W'(FRAME_CYC - 1);
				end
			end
			ST_RUN: begin
				if (!sync_en) begin
					s_nxt.cnt = (s_r.cnt == '0) ? CNT_W'(FRAME_CYC - 1) : s_r.cnt - CNT_W'(1);
					s_nxt.disch = 1'b0;
				end else if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - CNT_W'(1);
				end else begin
					s_nxt.disch = 1'b0;
				end
				if (trigger && !enc_busy) begin
					s_nxt.adc_go = 1'b1;
					s_nxt.enc_go = 1'b1;
					s_nxt.word = (s_r.err || ov) ? ERR_CODE : s_r.held;
				end
				if (sync_en && sync_valid && disch_en) begin
					s_nxt.disch = 1'b1;
					s_nxt.cnt = CNT_W'(DISCH_CYC - 1);
				end
			end
			default: s_nxt.state = ST_INIT_CONV;
		endcase

		// Undervolt: everything but pin and bus handshake state restarts
		if (uv) begin
			s_nxt.state = ST_INIT_CONV;
			s_nxt.ctrl = CTRL_RESET;
			s_nxt.err = 1'b0;
			s_nxt.held = '0;
			s_nxt.cnt = '0;
			s_nxt.disch = 1'b0;
			s_nxt.adc_go = 1'b0;
			s_nxt.enc_go = 1'b0;
			s_nxt.word = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.state <= ST_INIT_CONV;
			s_r.ctrl <= CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign s_axi_awready = !s_r.ax.aw_got && !s_r.ax.bvalid;
	assign s_axi_wready = !s_r.ax.w_got && !s_r.ax.bvalid;
	assign s_axi_bvalid = s_r.ax.bvalid;
	assign s_axi_bresp = s_r.ax.bresp;
	assign s_axi_arready = !s_r.ax.rvalid;
	assign s_axi_rvalid = s_r.ax.rvalid;
	assign s_axi_rdata = s_r.ax.rdata;
	assign s_axi_rresp = s_r.ax.rresp;
	assign adc_start = s_r.adc_go;
	assign discharge_pull_current = s_r.disch;

	// Checks
	property p_err_sticky;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.err |=> s_r.err;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

	property p_err_word;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.enc_go && s_r.err |-> s_r.word == ERR_CODE;
	endproperty
	a_err_word: assert property (p_err_word) else $error("frame without error code");

	property p_sync_gate;
		@(posedge aclk) disable iff (!rst_int_n)
		s_nxt.enc_go && sync_en |-> sync_valid;
	endproperty
	a_sync_gate: assert property (p_sync_gate) else $error("sync frame without pulse");

	property p_async_period;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.state == ST_RUN && !sync_en && s_r.cnt == '0 && !enc_busy
			|=> s_r.enc_go && s_r.adc_go;
	endproperty
	a_async_period: assert property (p_async_period) else $error("missed async frame");

	sequence s_pulse_disch;
		sync_valid && sync_en && disch_en && s_r.state == ST_RUN;
	endsequence
	property p_disch;
		@(posedge aclk) disable iff (!rst_int_n)
		s_pulse_disch |=> s_r.disch ##1 s_r.disch;
	endproperty
	a_disch: assert property (p_disch) else $error("no discharge after pulse");

	property p_disch_sync_only;
		@(posedge aclk) disable iff (!rst_int_n)
		!sync_en |=> !s_r.disch;
	endproperty
	a_disch_sync_only: assert property (p_disch_sync_only) else $error("discharge in async");

	property p_conv_before_run;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.state == ST_INIT_WAIT && s_nxt.state == ST_RUN |-> adc_done;
	endproperty
	a_conv_before_run: assert property (p_conv_before_run) else $error("run without data");

	property p_hold;
		@(posedge aclk) disable iff (!rst_int_n)
		adc_done |=> s_r.held == $past(adc_data);
	endproperty
	a_hold: assert property (p_hold) else $error("result not held");

	property p_conv_per_frame;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.adc_go && s_r.state == ST_RUN |-> s_r.enc_go;
	endproperty
	a_conv_per_frame: assert property (p_conv_per_frame) else $error("conversion without frame");

	property p_frame_in_run;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.enc_go |-> s_r.state == ST_RUN;
	endproperty
	a_frame_in_run: assert property (p_frame_in_run) else $error("frame before run phase");

	// Undervolt drops the internal reset, so this one only yields to the bus reset
	property p_uv_restart;
		@(posedge aclk) disable iff (!aresetn)
		uv |=> s_r.state == ST_INIT_CONV && s_r.ctrl == CTRL_RESET && !s_r.err;
	endproperty
	a_uv_restart: assert property (p_uv_restart) else $error("undervolt did not restart");

	property p_disch_enable;
		@(posedge aclk) disable iff (!rst_int_n)
		$rose(s_r.disch) |-> $past(sync_en) && $past(disch_en);
	endproperty
	a_disch_enable: assert property (p_disch_enable) else $error("discharge not enabled");

	property p_ctrl_write;
		@(posedge aclk) disable iff (!rst_int_n)
		s_r.ax.aw_got && s_r.ax.w_got && s_r.ax.awaddr == REG_CTRL_ADDR && s_r.ax.wstrb0
			|=> s_r.ctrl == $past(s_r.ax.wdata[2:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
endmodule

// ===== verif/sbsm_ctl_model.sv
// Control module model: sync pulse source and Manchester frame receiver
`timescale 1ns/10ps
module sbsm_ctl_model (
	input wire logic aclk, // Clock
	input wire logic line_mod, // Device modulation level
	input wire logic adc_start, // Marks the first half-bit of a frame
	output logic above, // Bus above upper threshold
	output logic below, // Bus below lower threshold
	output logic frame_ev, // One-cycle strobe after a frame
	output logic [11:0] frame_bits, // First-half levels, first bit on top
	output logic frame_ok // Every bit split into two equal halves
);
	logic s1, s2, s3, s4, ok, any;
	initial begin
		above = 1'b0;
		below = 1'b0;
		frame_ev = 1'b0;
		frame_bits = 12'h000;
		frame_ok = 1'b0;
	end
	// Voltage step on the supply, one level held for n 1 us windows
	task automatic seg(input int lvl, input int n);
		above <= (lvl == 2);
		below <= (lvl == 1);
		repeat (50 * n) @(posedge aclk);
	endtask
	// Single device on the bus; samples both ends of every half-bit
	always begin
		@(posedge aclk);
		frame_ev <= 1'b0;
		if (adc_start) begin
			ok = 1'b1;
			any = 1'b0;
			for (int i = 11; i >= 0; i--) begin
				@(posedge aclk);
				s1 = line_mod;
				repeat (198) @(posedge aclk);
				s2 = line_mod;
				repeat (2) @(posedge aclk);
				s3 = line_mod;
				repeat (198) @(posedge aclk);
				s4 = line_mod;
				ok = ok && (s1 === s2) && (s3 === s4) && (s1 !== s3);
				any = any | s1 | s3;
				frame_bits[i] <= s1;
				@(posedge aclk);
			end
			frame_ok <= ok;
			frame_ev <= any;
		end
	end
endmodule

// ===== verif/tb_top.sv
// Bench for the sync/Manchester transmitter: register bus, sync pulses, frames
`timescale 1ns/10ps
module tb_top;
	import sbsm_pkg::*;
	localparam logic [9:0] ERR = 10'h15a; // Arbitrary error payload
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, above, below, uvolt, ovolt;
	logic adc_start, adc_done, line_mod, disch, frame_ev, frame_ok, dprev;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rnd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [9:0] adc_data, held;
	logic [11:0] frame_bits;
	logic [2:0] dly;
	logic [33:0] aq[$];
	logic [43:0] fq[$];
	int n_mismatch, total_checks, cyc, tprev, n_fr, n_dis, n_st;
	sbsm_tx #(.FRAME_CYC(6000), .ERR_CODE(ERR)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.bus_above_upper(above), .bus_below_lower(below), .regulator_undervolt(uvolt),
		.regulator_overvolt(ovolt), .adc_start(adc_start), .adc_done(adc_done),
		.adc_data(adc_data), .line_mod(line_mod), .discharge_pull_current(disch));
	sbsm_ctl_model ctl (.aclk(aclk), .line_mod(line_mod), .adc_start(adc_start),
		.above(above), .below(below), .frame_ev(frame_ev), .frame_bits(frame_bits),
		.frame_ok(frame_ok));
	// Clock, 20 ns period
	always #10 aclk = ~aclk;
	task automatic chk(input logic [43:0] got, input logic [43:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Register write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		aq.push_back({RESP_OKAY, 32'h0});
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		aq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
	endtask
	// Expected frame: first-half level of each bit, start bits on top
	task automatic exp(input logic p, input logic [9:0] v, input int per);
		fq.push_back({per, ~({~p, 1'b0, v} ^ {12{p}})});
	endtask
	task automatic wfr;
		int k;
		k = n_fr;
		for (int i = 0; i < 20000 && n_fr == k; i++) @(posedge aclk);
		chk(n_fr != k, 1, "frame missing");
	endtask
	// Conversion source answering each start three cycles later
	always @(posedge aclk) begin
		n_dis += (disch === 1'b1 && dprev === 1'b0); // Pull-down as acknowledge
		dprev = disch;
		n_st += (adc_start === 1'b1);
		adc_done <= 1'b0;
		dly = {dly[1:0], adc_start === 1'b1};
		if (dly[2]) begin
			rnd = $urandom;
			adc_data <= rnd[9:0];
			adc_done <= 1'b1;
			held = rnd[9:0];
		end
	end
	// Result watcher: oldest note against each answer or frame
	always @(posedge aclk) begin
		cyc++;
		if ((rvalid && rready) || (bvalid && bready)) begin
			chk(aq.size() != 0, 1, "unexpected bus answer");
			if (aq.size() != 0) chk(rvalid ? {rresp, rdata} : {bresp, 32'h0}, aq.pop_front(), "bus");
		end
		if (frame_ev) begin
			chk(fq.size() != 0, 1, "unexpected frame");
			if (fq.size() != 0) begin
				chk(frame_bits, fq[0][11:0], "frame bits");
				chk(frame_ok, 1, "half-bit shape");
				if (fq[0][43:12] != 0) chk(cyc - tprev, fq[0][43:12], "period");
				void'(fq.pop_front());
			end
			tprev = cyc;
			n_fr++;
		end
	end
	// Watchdog
	initial begin
		repeat (90000) @(posedge aclk);
		n_mismatch++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, uvolt, ovolt} = '0;
		{awaddr, araddr, wdata, adc_done, adc_data, dly, held} = '0;
		wstrb = 4'hf;
		void'($urandom(40));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (20) @(posedge aclk);
		rd(REG_CTRL_ADDR, 32'h0, RESP_OKAY);
		rd(4'hc, 32'h0, RESP_SLVERR);
		rd(REG_DATA_ADDR, {22'h0, held}, RESP_OKAY);
		wr(REG_CTRL_ADDR, 32'h4);
		for (int i = 0; i < 2; i++) begin
			exp(1'b0, held, i * 6000);
			wfr();
		end
		wr(REG_CTRL_ADDR, 32'h5);
		exp(1'b1, held, 6000);
		wfr();
		wr(REG_CTRL_ADDR, 32'h6);
		repeat (6500) @(posedge aclk);
		ctl.seg(1, 3);
		ctl.seg(2, 4);
		ctl.seg(0, 5);
		ctl.seg(1, 1);
		chk(n_dis, 0, "early pulse taken");
		exp(1'b0, held, 0);
		ctl.seg(2, 4);
		ctl.seg(0, 20);
		ctl.seg(2, 10);
		ctl.seg(0, 1);
		wfr();
		chk(n_dis, 1, "discharge on pulse");
		repeat (450) @(posedge aclk);
		exp(1'b0, held, 0);
		ctl.seg(2, 8);
		ctl.seg(0, 1);
		wfr();
		repeat (450) @(posedge aclk);
		// Period counter sits at zero in sync mode, so async resumes with a frame at once
		exp(1'b0, held, 0);
		wr(REG_CTRL_ADDR, 32'h0);
		ovolt <= 1'b1;
		repeat (5) @(posedge aclk);
		ovolt <= 1'b0;
		repeat (5) @(posedge aclk);
		rd(REG_STAT_ADDR, 32'h7, RESP_OKAY);
		wfr();
		for (int i = 0; i < 2; i++) begin
			exp(1'b0, ERR, 6000);
			wfr();
		end
		wr(REG_CTRL_ADDR, 32'h1);
		uvolt <= 1'b1;
		repeat (5) @(posedge aclk);
		uvolt <= 1'b0;
		repeat (20) @(posedge aclk);
		rd(REG_CTRL_ADDR, 32'h0, RESP_OKAY);
		rd(REG_STAT_ADDR, 32'h2, RESP_OKAY);
		exp(1'b0, held, 0);
		wfr();
		chk(n_dis, 2, "discharge count");
		chk(n_st, n_fr + 2, "conversion count");
		report_and_stop();
	end
endmodule
